// ===== hdl/smi_status_latches.sv
// Purpose: System-management status latches with enables and APB access
// Assumes: Single 25 MHz clock; pins pass a two-stage synchroniser
// Notes:   Zero wait-state APB slave; unmapped access answers pslverr
//
// Design decision made here: the APB interface to the registers.
`timescale 1ns/1ps
module smi_status_latches (
  input  wire logic                     clock,
  input  wire logic                     arst_n,
  input  wire logic                     psel,
  input  wire logic                     penable,
  input  wire logic                     pwrite,
  input  wire logic [smi_pkg::ADDR_W-1:0] paddr,
  input  wire logic [31:0]              pwdata,
  output logic      [31:0]              prdata,
  output logic                          pready,
  output logic                          pslverr,
  input  wire smi_pkg::periph_src_t     periph_src,
  input  wire logic                     ring_indicator_one_n,
  input  wire logic                     ring_indicator_two_n,
  input  wire logic [7:0]               gpio_a_pins,
  input  wire logic [7:0]               gpio_b_pins,
  input  wire logic [6:0]               gpio_c_pins,
  output logic                          group_sysmgmt_irq_out
);

  // ----------------------------------------------------------------
  // Pin synchronisation and edge detection
  // ----------------------------------------------------------------
  logic [24:0] pins_sync;
  logic [24:0] pins_prev;
  logic [24:0] next_pins_prev;

  sync_two_stage #(
    .WIDTH(25)
  ) u_sync (
    .clock   (clock),
    .arst_n  (arst_n),
    .async_in({ring_indicator_two_n, ring_indicator_one_n, gpio_c_pins, gpio_b_pins, gpio_a_pins}),
    .sync_out(pins_sync)
  );

  // Previous sample for edge detection; reads synchronised stage only
  always_comb begin
    next_pins_prev = pins_sync;
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      pins_prev <= '0; // Same as the synchroniser's reset, so release gives no false ring edge
    end else begin
      pins_prev <= next_pins_prev;
    end
  end

  // GPIO events are rising edges; ring indicators are falling edges
  logic [22:0] gpio_rise;
  logic        ring_one_fall;
  logic        ring_two_fall;
  assign gpio_rise     = pins_sync[22:0] & ~pins_prev[22:0];
  assign ring_one_fall = ~pins_sync[23] & pins_prev[23];
  assign ring_two_fall = ~pins_sync[24] & pins_prev[24];

  // ----------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------
  // Word index from a byte address; misaligned gives an invalid index
  function automatic logic [7:0] word_index(input logic [smi_pkg::ADDR_W-1:0] a);
    word_index = (a[1:0] == 2'h0) ? a[smi_pkg::ADDR_W-1:2] : 8'hff;
  endfunction

  logic [7:0] acc_idx;
  logic       acc_done;
  logic       wr_done;
  logic       is_sts;
  logic       is_en;
  logic [1:0] reg_sel;
  assign acc_idx  = word_index(paddr);
  assign acc_done = psel && penable && pready;
  assign wr_done  = acc_done && pwrite;
  assign is_sts   = (acc_idx >= smi_pkg::IDX_STS_PERIPH) && (acc_idx <= smi_pkg::IDX_STS_GPIO_C);
  assign is_en    = (acc_idx >= smi_pkg::IDX_EN_PERIPH) && (acc_idx <= smi_pkg::IDX_EN_GPIO_C);
  assign reg_sel  = is_sts ? 2'(acc_idx - smi_pkg::IDX_STS_PERIPH) : 2'(acc_idx - smi_pkg::IDX_EN_PERIPH);

  // ----------------------------------------------------------------
  // Status and enable registers
  // ----------------------------------------------------------------
  logic [7:0] status      [smi_pkg::NUM_REGS];
  logic [7:0] enable      [smi_pkg::NUM_REGS];
  logic [7:0] next_status [smi_pkg::NUM_REGS];
  logic [7:0] next_enable [smi_pkg::NUM_REGS];
  logic [7:0] set_vec     [smi_pkg::NUM_REGS];
  logic [7:0] impl_vec    [smi_pkg::NUM_REGS];
  logic [7:0] w1c_vec     [smi_pkg::NUM_REGS];

  // Event sources per register, implemented bits and clearable bits
  always_comb begin
    set_vec[0] = 8'h00;
    set_vec[0][smi_pkg::BIT_SMBUS]    = periph_src.smbus_event_status;
    set_vec[0][smi_pkg::BIT_RING_ONE] = ring_one_fall;
    set_vec[0][smi_pkg::BIT_PORT12]   = periph_src.kbd_port12_event;
    set_vec[0][smi_pkg::BIT_RING_TWO] = ring_two_fall;
    set_vec[1]  = gpio_rise[7:0];
    set_vec[2]  = gpio_rise[15:8]; // Bit 5 is the tachometer_event
    set_vec[3]  = {1'b0, gpio_rise[22:16]};
    impl_vec[0] = smi_pkg::IMPL_PERIPH;
    impl_vec[1] = smi_pkg::IMPL_GPIO_AB;
    impl_vec[2] = smi_pkg::IMPL_GPIO_AB;
    impl_vec[3] = smi_pkg::IMPL_GPIO_C;
    w1c_vec[0]  = smi_pkg::W1C_PERIPH;
    w1c_vec[1]  = smi_pkg::IMPL_GPIO_AB;
    w1c_vec[2]  = smi_pkg::IMPL_GPIO_AB;
    w1c_vec[3]  = smi_pkg::IMPL_GPIO_C;
  end

  // Next values: set beats clear, reserved bits held at zero
  always_comb begin
    for (int i = 0; i < smi_pkg::NUM_REGS; i++) begin
      logic [7:0] clr;
      clr = 8'h00;
      if (wr_done && is_sts && (reg_sel == 2'(i))) begin
        clr = pwdata[7:0] & w1c_vec[i];
      end
      next_status[i] = ((status[i] & ~clr) | set_vec[i]) & impl_vec[i];
      next_enable[i] = enable[i];
      if (wr_done && is_en && (reg_sel == 2'(i))) begin
        next_enable[i] = pwdata[7:0] & impl_vec[i];
      end
    end
    // Mouse and keyboard bits are copies; only the source clears them
    next_status[0][smi_pkg::BIT_MOUSE] = periph_src.mouse_irq_status;
    next_status[0][smi_pkg::BIT_KBD]   = periph_src.keyboard_irq_status;
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      for (int i = 0; i < smi_pkg::NUM_REGS; i++) begin
        status[i] <= smi_pkg::STS_RESET;
        enable[i] <= smi_pkg::EN_RESET;
      end
    end else begin
      for (int i = 0; i < smi_pkg::NUM_REGS; i++) begin
        status[i] <= next_status[i];
        enable[i] <= next_enable[i];
      end
    end
  end

  // ----------------------------------------------------------------
  // Combined interrupt output
  // ----------------------------------------------------------------
  logic next_irq;

  // One register stage keeps the pin glitch free at the cost of a cycle
  always_comb begin
    next_irq = 1'b0;
    for (int i = 0; i < smi_pkg::NUM_REGS; i++) begin
      next_irq = next_irq | (|(status[i] & enable[i]));
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      group_sysmgmt_irq_out <= 1'b0;
    end else begin
      group_sysmgmt_irq_out <= next_irq;
    end
  end

  // ----------------------------------------------------------------
  // APB answer
  // ----------------------------------------------------------------
  logic [31:0] next_prdata;
  logic        next_pready;
  logic        next_pslverr;

  // Answer computed in the setup cycle, presented in the first access cycle
  always_comb begin
    next_prdata  = 32'h0000_0000;
    next_pready  = 1'b0;
    next_pslverr = 1'b0;
    if (psel && !penable) begin
      next_pready = 1'b1;
      if (is_sts) begin
        next_prdata = {24'h00_0000, status[reg_sel]};
      end else if (is_en) begin
        next_prdata = {24'h00_0000, enable[reg_sel]};
      end else begin
        next_pslverr = 1'b1;
      end
      if (pwrite) begin
        next_prdata = 32'h0000_0000;
      end
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      prdata  <= next_prdata;
      pready  <= next_pready;
      pslverr <= next_pslverr;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking chk_clk @(posedge clock);
  endclocking
  default disable iff (!arst_n);

  logic wr_sts0;
  logic wr_sts1;
  logic wr_sts2;
  logic wr_sts3;
  logic any_unmasked;
  assign wr_sts0      = wr_done && (acc_idx == smi_pkg::IDX_STS_PERIPH);
  assign wr_sts1      = wr_done && (acc_idx == smi_pkg::IDX_STS_GPIO_A);
  assign wr_sts2      = wr_done && (acc_idx == smi_pkg::IDX_STS_GPIO_B);
  assign wr_sts3      = wr_done && (acc_idx == smi_pkg::IDX_STS_GPIO_C);
  assign any_unmasked = |{status[0] & enable[0], status[1] & enable[1],
                          status[2] & enable[2], status[3] & enable[3]};

  sequence apb_setup_s;
    psel && !penable;
  endsequence

  sequence apb_answer_s;
    pready ##1 !pready;
  endsequence

  apb_answer_a: assert property (apb_setup_s |=> apb_answer_s)
    else $error("APB answer not given in first access cycle");

  periph_reserved_a: assert property (status[0][7:6] == 2'h0)
    else $error("Reserved peripheral status bits set");

  smbus_clear_a: assert property (
    wr_sts0 && pwdata[smi_pkg::BIT_SMBUS] && !periph_src.smbus_event_status
    |=> !status[0][smi_pkg::BIT_SMBUS])
    else $error("SMBus status not cleared by write of one");

  source_copy_a: assert property (##1 status[0][1:0] == $past({periph_src.keyboard_irq_status,
                                                             periph_src.mouse_irq_status}))
    else $error("Mouse or keyboard status does not follow its source");

  port12_clear_a: assert property (
    wr_sts0 && pwdata[smi_pkg::BIT_PORT12] && !periph_src.kbd_port12_event
    |=> !status[0][smi_pkg::BIT_PORT12])
    else $error("Port-12 status not cleared by write of one");

  gpio_a_wins_a: assert property (
    wr_sts1 && pwdata[0] && gpio_rise[0] |=> status[1][0])
    else $error("GPIO event lost to a same-cycle clear");

  tach_latch_a: assert property (
    gpio_rise[8 + smi_pkg::BIT_TACH] |=> status[2][smi_pkg::BIT_TACH]
    ##1 (status[2][smi_pkg::BIT_TACH] || $past(wr_sts2)))
    else $error("Tachometer event not latched");

  gpio_c_top_a: assert property (status[3][7] == 1'b0)
    else $error("Unimplemented top bit of third GPIO register set");

  irq_gate_a: assert property (any_unmasked |=> group_sysmgmt_irq_out)
    else $error("Enabled status did not raise the interrupt");

  irq_block_a: assert property (!any_unmasked |=> !group_sysmgmt_irq_out)
    else $error("Interrupt raised with no enabled status");

  sticky_hold_a: assert property (
    !wr_sts1 |=> ((status[1] & $past(status[1])) == $past(status[1])))
    else $error("Latched GPIO status dropped without a clear");

  // A zero in the write data must leave a latched bit alone
  zero_write_a: assert property (
    wr_sts0 && !pwdata[smi_pkg::BIT_RING_ONE] && status[0][smi_pkg::BIT_RING_ONE]
    |=> status[0][smi_pkg::BIT_RING_ONE])
    else $error("Ring status lost on a write of zero");

  ring_latch_a: assert property (ring_one_fall |=> status[0][smi_pkg::BIT_RING_ONE])
    else $error("Ring indicator fall not latched");

  gpio_a_latch_a: assert property (
    gpio_rise[7:0] != 8'h00 |=> (status[1] & $past(gpio_rise[7:0])) == $past(gpio_rise[7:0]))
    else $error("First GPIO event not latched");

  gpio_b_clear_a: assert property (
    wr_sts2 && pwdata[0] && !gpio_rise[8] |=> !status[2][0])
    else $error("Second GPIO status not cleared by write of one");

  gpio_c_clear_a: assert property (
    wr_sts3 && pwdata[0] && !gpio_rise[16] |=> !status[3][0])
    else $error("Third GPIO status not cleared by write of one");

  // Unmapped or misaligned setup must be refused in the access cycle
  sequence unmapped_setup_s;
    psel && !penable && !is_sts && !is_en;
  endsequence

  unmapped_err_a: assert property (unmapped_setup_s |=> pready && pslverr)
    else $error("Unmapped access not refused");

endmodule // smi_status_latches

// ===== include/smi_pkg.sv
// Purpose: Constants and types for the system-management status latches
// Assumes: APB slave, 32-bit data, one aligned word per register index
// Notes:   Byte address of a register is four times its index
// How it works
// - Peripheral status at index 0x11, six bits (0 to 5), zero after standby-rail reset
// - Writing one to peripheral bits 2 to 6 clears them; zero leaves them
// - Mouse and keyboard bits copy their sources; host writes never touch them
// - Writing one clears only the latched port-12 bit; source clears itself
// - Index 0x12 latches gpio_evt_20,21,22,60,24,25,26,27; write one clears
// - Index 0x13 latches gpio_evt_30..33,41, tachometer, 43, 61; write one clears
// - Index 0x14 latches gpio_evt_50..56 in bits 0 to 6; write one clears
// - A latched bit reaches the combined output only while its enable is one
package smi_pkg;

  // ----------------------------------------------------------------
  // Register indexes (byte address = index * 4)
  // ----------------------------------------------------------------
  localparam logic [7:0] IDX_STS_PERIPH = 8'h11;
  localparam logic [7:0] IDX_STS_GPIO_A = 8'h12;
  localparam logic [7:0] IDX_STS_GPIO_B = 8'h13;
  localparam logic [7:0] IDX_STS_GPIO_C = 8'h14;
  localparam logic [7:0] IDX_EN_PERIPH  = 8'h18;
  localparam logic [7:0] IDX_EN_GPIO_A  = 8'h19;
  localparam logic [7:0] IDX_EN_GPIO_B  = 8'h1a;
  localparam logic [7:0] IDX_EN_GPIO_C  = 8'h1b;

  // ----------------------------------------------------------------
  // Field positions, masks and reset values
  // ----------------------------------------------------------------
  localparam int         NUM_REGS      = 4;
  localparam int         ADDR_W        = 10;
  localparam int         BIT_MOUSE     = 0;
  localparam int         BIT_KBD       = 1;
  localparam int         BIT_SMBUS     = 2;
  localparam int         BIT_RING_ONE  = 3;
  localparam int         BIT_PORT12    = 4;
  localparam int         BIT_RING_TWO  = 5;
  localparam int         BIT_TACH      = 5;
  localparam logic [7:0] IMPL_PERIPH   = 8'h3f;
  localparam logic [7:0] IMPL_GPIO_AB  = 8'hff;
  localparam logic [7:0] IMPL_GPIO_C   = 8'h7f;
  localparam logic [7:0] W1C_PERIPH    = 8'h7c;
  localparam logic [7:0] STS_RESET     = 8'h00;
  localparam logic [7:0] EN_RESET      = 8'h00;

  // Internal same-clock peripheral sources
  typedef struct packed {
    logic mouse_irq_status;
    logic keyboard_irq_status;
    logic smbus_event_status;
    logic kbd_port12_event;
  } periph_src_t;

endpackage

// ===== hdl/sync_two_stage.sv
// Purpose: Two flip-flop synchroniser for pin inputs
// Assumes: Inputs are asynchronous levels
// Notes:   Only the second stage leaves this module
`timescale 1ns/1ps
module sync_two_stage #(
  parameter int WIDTH = 8
) (
  input  wire logic             clock,
  input  wire logic             arst_n,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] stage_one;

  // ----------------------------------------------------------------
  // Capture chain; first stage feeds only the second
  // ----------------------------------------------------------------
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      stage_one <= '0;
      sync_out  <= '0;
    end else begin
      stage_one <= async_in;
      sync_out  <= stage_one;
    end
  end

endmodule // sync_two_stage

// ===== tb/smi_event_source.sv
// Purpose: Event sources on the far side of the status latches
// Assumes: Tasks are called just after a rising clock edge
// Notes:   Pins return to idle after each pulse, as real sources do
`timescale 1ns/1ps
module smi_event_source (
  input  wire logic           clock,
  output smi_pkg::periph_src_t periph_src,
  output logic                ring_indicator_one_n,
  output logic                ring_indicator_two_n,
  output logic [7:0]          gpio_a_pins,
  output logic [7:0]          gpio_b_pins,
  output logic [6:0]          gpio_c_pins
);
  // Idle levels: ring lines high, all else low
  initial begin
    periph_src = '0;
    ring_indicator_one_n = 1'b1;
    ring_indicator_two_n = 1'b1;
    gpio_a_pins = 8'h00;
    gpio_b_pins = 8'h00;
    gpio_c_pins = 7'h00;
  end

  // Rising edges on one pin group, held past the synchroniser
  task automatic gpio_pulse(input int sel, input logic [7:0] v);
    @(posedge clock);
    if (sel == 0) gpio_a_pins <= v;
    else if (sel == 1) gpio_b_pins <= v;
    else gpio_c_pins <= v[6:0];
    repeat (4) @(posedge clock);
    gpio_a_pins <= 8'h00;
    gpio_b_pins <= 8'h00;
    gpio_c_pins <= 7'h00;
    repeat (3) @(posedge clock);
  endtask

  // Level sources; the source itself clears them
  task automatic set_src(input smi_pkg::periph_src_t s);
    @(posedge clock);
    periph_src <= s;
    repeat (2) @(posedge clock);
  endtask

  // Both ring lines fall, then go idle again
  task automatic ring_fall();
    @(posedge clock);
    ring_indicator_one_n <= 1'b0;
    ring_indicator_two_n <= 1'b0;
    repeat (4) @(posedge clock);
    ring_indicator_one_n <= 1'b1;
    ring_indicator_two_n <= 1'b1;
    repeat (3) @(posedge clock);
  endtask
endmodule // smi_event_source

// ===== tb/smi_status_latches_test.sv
// Purpose: Self-checking bench for the status latches
// Assumes: APB slave answers in its own time, byte address = index * 4
// Notes:   Random values from an 8-bit shift register seeded with 0x30
`timescale 1ns/1ps
module smi_status_latches_test;
  logic                 clock = 1'b0;
  logic                 arst_n = 1'b0;
  logic                 psel = 1'b0;
  logic                 penable = 1'b0;
  logic                 pwrite = 1'b0;
  logic [9:0]           paddr = 10'h000;
  logic [31:0]          pwdata = 32'h0;
  logic [31:0]          prdata;
  logic                 pready;
  logic                 pslverr;
  smi_pkg::periph_src_t periph_src;
  logic                 ring_one_n;
  logic                 ring_two_n;
  logic [7:0]           pin_a;
  logic [7:0]           pin_b;
  logic [6:0]           pin_c;
  logic                 irq;
  logic [7:0]           seed = 8'h30;
  logic [7:0]           v;
  logic [7:0]           m;
  logic [7:0]           imp;
  logic [31:0]          rd;
  logic                 er;
  int                   err_count = 0;
  int                   checks = 0;

  always #20 clock = ~clock;

  smi_status_latches DUT (.clock(clock), .arst_n(arst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .periph_src(periph_src), .ring_indicator_one_n(ring_one_n),
    .ring_indicator_two_n(ring_two_n), .gpio_a_pins(pin_a), .gpio_b_pins(pin_b),
    .gpio_c_pins(pin_c), .group_sysmgmt_irq_out(irq));

  smi_event_source src (.clock(clock), .periph_src(periph_src), .ring_indicator_one_n(ring_one_n),
    .ring_indicator_two_n(ring_two_n), .gpio_a_pins(pin_a), .gpio_b_pins(pin_b), .gpio_c_pins(pin_c));

  // Next pseudo-random byte
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      err_count++;
      $display("unexpected %s: expected %h seen %h", n, e, g);
    end
  endtask

  // One APB transfer; request held until pready is seen high at a rising edge
  task automatic apb(input logic w, input logic [9:0] a, input logic [7:0] d);
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge clock);
    penable <= 1'b1;
    do @(posedge clock); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd_chk(input logic [9:0] a, input logic [7:0] e);
    apb(1'b0, a, 8'h00);
    chk("status", {24'h0, e}, rd);
  endtask

  // Interrupt level, looked at once the lag has passed
  task automatic irq_chk(input logic e);
    repeat (3) @(negedge clock);
    chk("irq", {31'h0, e}, {31'h0, irq});
  endtask

  task automatic finish_test();
    $display("checks %0d err_count %0d", checks, err_count);
    if (err_count == 0 && checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // Watchdog: far beyond the few hundred cycles the tests need
  initial begin
    repeat (20000) @(posedge clock);
    err_count++;
    finish_test();
  end

  initial begin
    repeat (12) @(posedge clock);
    arst_n <= 1'b1;
    // Reset values of status and enable words
    for (int i = 0; i < 4; i++) begin
      rd_chk(10'h044 + 10'(4 * i), 8'h00);
      rd_chk(10'h060 + 10'(4 * i), 8'h00);
    end
    irq_chk(1'b0);
    apb(1'b0, 10'h07c, 8'h00);
    chk("pslverr", 32'h1, {31'h0, er});
    // Random pin events, partial clears, then full clears
    for (int k = 0; k < 6; k++) begin
      seed = lfsr(seed);
      v = seed;
      seed = lfsr(seed);
      m = seed;
      imp = (k % 3 == 2) ? 8'h7f : 8'hff;
      src.gpio_pulse(k % 3, v);
      rd_chk(10'h048 + 10'(4 * (k % 3)), v & imp);
      apb(1'b1, 10'h048 + 10'(4 * (k % 3)), m);
      rd_chk(10'h048 + 10'(4 * (k % 3)), v & ~m & imp);
      apb(1'b1, 10'h048 + 10'(4 * (k % 3)), 8'hff);
      rd_chk(10'h048 + 10'(4 * (k % 3)), 8'h00);
    end
    // Mouse and keyboard follow their sources only
    src.set_src(4'hc);
    rd_chk(10'h044, 8'h03);
    apb(1'b1, 10'h044, 8'hff);
    rd_chk(10'h044, 8'h03);
    src.set_src(4'h3);
    src.set_src(4'h0);
    src.ring_fall();
    rd_chk(10'h044, 8'h3c);
    apb(1'b1, 10'h044, 8'h10);
    rd_chk(10'h044, 8'h2c);
    apb(1'b1, 10'h044, 8'hff);
    rd_chk(10'h044, 8'h00);
    // A held event outlasts a clearing write
    src.set_src(4'h2);
    apb(1'b1, 10'h044, 8'h04);
    rd_chk(10'h044, 8'h04);
    src.set_src(4'h0);
    apb(1'b1, 10'h044, 8'h04);
    // Pin event and clearing write meet in one cycle; the event stays
    fork
      src.gpio_pulse(0, 8'h01);
      begin
        @(posedge clock);
        apb(1'b1, 10'h048, 8'h01);
      end
    join
    rd_chk(10'h048, 8'h01);
    apb(1'b1, 10'h048, 8'h01);
    rd_chk(10'h048, 8'h00);
    // Interrupt only through an enabled bit
    src.gpio_pulse(0, 8'h01);
    irq_chk(1'b0);
    apb(1'b1, 10'h064, 8'h01);
    irq_chk(1'b1);
    apb(1'b1, 10'h048, 8'h01);
    irq_chk(1'b0);
    // Reset in mid-run clears latched and enabled bits
    src.gpio_pulse(1, 8'h81);
    apb(1'b1, 10'h068, 8'hff);
    irq_chk(1'b1);
    @(posedge clock);
    arst_n <= 1'b0;
    repeat (3) @(posedge clock);
    arst_n <= 1'b1;
    rd_chk(10'h04c, 8'h00);
    rd_chk(10'h068, 8'h00);
    rd_chk(10'h044, 8'h00);
    irq_chk(1'b0);
    finish_test();
  end
endmodule // smi_status_latches_test
